//--- byte_fifo_if.sv
// byte stream carrier between the uart core and its fifos
`timescale 1ns/1ns
`include "uart_defs.svh"

interface byte_fifo_if;
  logic [7:0]          wr_data;
  logic                wr_valid;
  logic                wr_ready;
  logic [7:0]          rd_data;
  logic                rd_valid;
  logic                rd_ready;
  logic [`LEVEL_W-1:0] level;

  modport store (
    input  wr_data,
    input  wr_valid,
    output wr_ready,
    output rd_data,
    output rd_valid,
    input  rd_ready,
    output level
  );

  modport user (
    output wr_data,
    output wr_valid,
    input  wr_ready,
    input  rd_data,
    input  rd_valid,
    output rd_ready,
    input  level
  );
endinterface

//--- hci_uart.sv
// host-interface uart core with flow control, programmable baud and wake lines
//
// What this block does
// - four wires rx, tx, rts, cts; rts and cts give hardware flow control
// - baud rate accepted between 115200 and 1500000, requests clamped to that range
// - fractional baud generator gives exact average rates including intermediate ones
// - new rate loaded on command, applied once both engines are idle
// - 16x oversampling, majority vote at mid-bit tolerates combined five percent error
// - separate 1040-byte receive and transmit fifos
// - bytes pass unchanged so h4 indicator and packet framing stay intact
// - link runs at 115.2 kbaud from reset until the host changes it
// - sleep allowed only when host wake request is off and radio idle
// - host wake raised while bytes wait for the host, else released
// - wake sideband stays inactive until enabled by command
`timescale 1ns/1ns
`include "uart_defs.svh"

module hci_uart
  import uart_pkg::*;
#(
  parameter int FIFO_DEPTH = `HCI_FIFO_DEPTH
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  input  wire logic               rx_i,
  output      logic               tx_o,
  input  wire logic               cts_n_i,
  output      logic               rts_n_o,
  input  wire logic [7:0]         tx_data_i,
  input  wire logic               tx_valid_i,
  output      logic               tx_ready_o,
  output      logic [7:0]         rx_data_o,
  output      logic               rx_valid_o,
  input  wire logic               rx_ready_i,
  input  wire logic [`BAUD_W-1:0] baud_rate_i,
  input  wire logic               baud_load_i,
  output      logic [`BAUD_W-1:0] baud_rate_o,
  input  wire logic               wake_enable_i,
  input  wire logic               device_wake_request_i,
  input  wire logic               radio_idle_i,
  output      logic               host_wake_o,
  output      logic               sleep_allowed_o,
  output      logic               frame_error_o,
  output      logic               overrun_o
);
  localparam logic [`LEVEL_W-1:0] RTS_LEVEL = `LEVEL_W'(FIFO_DEPTH) - `RTS_MARGIN;

  // ****************************************************************
  // fifos
  // ****************************************************************
  byte_fifo_if tx_f ();
  byte_fifo_if rx_f ();

  sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .f       (tx_f.store)
  );

  sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .f       (rx_f.store)
  );

  // host-facing sides come straight from the fifo registers
  assign tx_f.wr_data  = tx_data_i;
  assign tx_f.wr_valid = tx_valid_i;
  assign tx_ready_o    = tx_f.wr_ready;
  assign rx_data_o     = rx_f.rd_data;
  assign rx_valid_o    = rx_f.rd_valid;
  assign rx_f.rd_ready = rx_ready_i;

  // ****************************************************************
  // baud generator
  // ****************************************************************
  baud_t       baud_q;
  baud_t       pend_q;
  logic        pend_v_q;
  logic [26:0] acc_q;
  logic [26:0] acc_sum;
  logic        tick;
  baud_t       req_clamped;
  tx_state_t   tx_state_q;
  rx_state_t   rx_state_q;
  logic        engines_idle;

  // accumulate 16*baud per clock, tick on wrap: exact on average, jitter one clock
  assign acc_sum = acc_q + 27'({baud_q, 4'h0});
  assign tick    = (acc_sum >= `CLK_HZ);
  assign engines_idle = (tx_state_q == TX_IDLE) && (rx_state_q == RX_IDLE);

  always_comb begin
    if (baud_rate_i < `BAUD_MIN) begin
      req_clamped = `BAUD_MIN;
    end else if (baud_rate_i > `BAUD_MAX) begin
      req_clamped = `BAUD_MAX;
    end else begin
      req_clamped = baud_rate_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= '0;
    end else if (ce_i) begin
      if (pend_v_q && engines_idle) begin
        acc_q <= '0;
      end else if (tick) begin
        acc_q <= acc_sum - `CLK_HZ;
      end else begin
        acc_q <= acc_sum;
      end
    end
  end

  // a new rate never cuts a character in half, it waits for both engines
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_q   <= `BAUD_DEFAULT;
      pend_q   <= `BAUD_DEFAULT;
      pend_v_q <= 1'b0;
    end else if (ce_i) begin
      if (pend_v_q && engines_idle) begin
        baud_q   <= pend_q;
        pend_v_q <= 1'b0;
      end
      if (baud_load_i) begin
        pend_q   <= req_clamped;
        pend_v_q <= 1'b1;
      end
    end
  end

  assign baud_rate_o = baud_q;

  // ****************************************************************
  // transmitter
  // ****************************************************************
  logic [3:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic       tx_q;

  // a character starts only on a tick with cts asserted; it then runs to its stop bit
  assign tx_f.rd_ready = (tx_state_q == TX_IDLE) && tick && !cts_n_i && !pend_v_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= '0;
      tx_bit_q   <= '0;
      tx_sh_q    <= '0;
      tx_q       <= 1'b1;
    end else if (ce_i) begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_q <= 1'b1;
          if (tx_f.rd_ready && tx_f.rd_valid) begin
            tx_sh_q    <= tx_f.rd_data;
            tx_q       <= 1'b0;
            tx_cnt_q   <= '0;
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          if (tick) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_cnt_q == `OVS_LAST) begin
              tx_q       <= tx_sh_q[0];
              tx_bit_q   <= '0;
              tx_state_q <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tick) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_cnt_q == `OVS_LAST) begin
              if (tx_bit_q == `LAST_BIT) begin
                tx_q       <= 1'b1;
                tx_state_q <= TX_STOP;
              end else begin
                tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                tx_q     <= tx_sh_q[1];
                tx_bit_q <= tx_bit_q + 1'b1;
              end
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_cnt_q == `OVS_LAST) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
          tx_q       <= 1'b1;
        end
      endcase
    end
  end

  assign tx_o = tx_q;

  // ****************************************************************
  // receiver
  // ****************************************************************
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic [2:0] vote_q;
  logic       vote;
  logic       rx_push_q;
  logic       ferr_q;
  logic       ovr_q;

  assign vote = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]);
  assign rx_f.wr_data  = rx_sh_q;
  assign rx_f.wr_valid = rx_push_q;

  // three samples around mid-bit; stop ends early so a fast sender is not lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vote_q <= 3'h7;
    end else if (ce_i && tick && (rx_cnt_q >= `VOTE_FIRST) && (rx_cnt_q <= `VOTE_LAST)) begin
      vote_q <= {vote_q[1:0], rx_i};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= '0;
      rx_sh_q    <= '0;
      rx_push_q  <= 1'b0;
      ferr_q     <= 1'b0;
    end else if (ce_i) begin
      rx_push_q <= 1'b0;
      ferr_q    <= 1'b0;
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= '0;
          if (tick && !rx_i) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
            if (rx_cnt_q == `START_CHECK && rx_i) begin
              rx_state_q <= RX_IDLE;
            end else if (rx_cnt_q == `OVS_LAST) begin
              rx_bit_q   <= '0;
              rx_state_q <= RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
            if (rx_cnt_q == `OVS_LAST) begin
              rx_sh_q  <= {vote, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 1'b1;
              if (rx_bit_q == `LAST_BIT) begin
                rx_state_q <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
            if (rx_cnt_q == `STOP_DONE) begin
              rx_push_q  <= vote;
              ferr_q     <= !vote;
              rx_state_q <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // a byte arriving at a full fifo is dropped and flagged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_q <= 1'b0;
    end else if (ce_i) begin
      ovr_q <= rx_push_q && !rx_f.wr_ready;
    end
  end

  assign frame_error_o = ferr_q;
  assign overrun_o     = ovr_q;

  // ****************************************************************
  // flow control and wake sideband
  // ****************************************************************
  logic rts_n_q;
  logic host_wake_q;
  logic sleep_q;

  // margin leaves room for the characters the host sends before it sees rts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts_n_q     <= 1'b0;
      host_wake_q <= 1'b0;
      sleep_q     <= 1'b0;
    end else if (ce_i) begin
      rts_n_q     <= (rx_f.level >= RTS_LEVEL);
      host_wake_q <= wake_enable_i && (tx_f.rd_valid || tx_state_q != TX_IDLE);
      sleep_q     <= wake_enable_i && !device_wake_request_i && radio_idle_i
                     && engines_idle && !tx_f.rd_valid;
    end
  end

  assign rts_n_o         = rts_n_q;
  assign host_wake_o     = host_wake_q;
  assign sleep_allowed_o = sleep_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  cts_blocks_start_a: assert property (ce_i && cts_n_i && tx_state_q == TX_IDLE
    |=> tx_state_q == TX_IDLE) else $error("character started with cts deasserted");
  rts_near_full_a: assert property (ce_i && rx_f.level >= RTS_LEVEL |=> rts_n_o)
    else $error("rts still asserted near full");
  start_bit_low_a: assert property (ce_i && tx_f.rd_ready && tx_f.rd_valid
    |=> !tx_o && tx_state_q == TX_START) else $error("start bit missing");
  stop_bit_high_a: assert property (tx_state_q == TX_STOP |-> tx_o)
    else $error("stop bit not high");
  baud_in_range_a: assert property (baud_q >= `BAUD_MIN && baud_q <= `BAUD_MAX)
    else $error("baud out of range");
  baud_apply_a: assert property (ce_i && pend_v_q && engines_idle && !baud_load_i
    |=> baud_q == $past(pend_q) && !pend_v_q) else $error("rate not applied");
  acc_wrap_a: assert property (acc_q < `CLK_HZ)
    else $error("baud accumulator overrun");
  wake_off_a: assert property (ce_i && !wake_enable_i |=> !host_wake_o && !sleep_allowed_o)
    else $error("wake sideband active while disabled");
  host_wake_a: assert property (ce_i && wake_enable_i && tx_f.rd_valid |=> host_wake_o)
    else $error("host not woken with traffic");
  device_wake_request_a: assert property (ce_i && device_wake_request_i |=> !sleep_allowed_o)
    else $error("sleep allowed against wake request");

  tx_char_c: cover property (tx_state_q == TX_STOP ##1 tx_state_q == TX_IDLE);
  rx_byte_c: cover property (rx_push_q && rx_f.wr_ready);
  baud_change_c: cover property (pend_v_q ##1 !pend_v_q);
  rts_drop_c: cover property (!rts_n_o ##1 rts_n_o);
endmodule

//--- hci_uart_tb.sv
// self-checking bench for the host-interface uart
`timescale 1ns/1ns
`include "uart_defs.svh"

module hci_uart_tb;
  // small depth keeps fill and drain short; rts margin still lands mid-buffer
  localparam int DEPTH = 32;
  logic               clk_i;
  logic               rst_n_i;
  logic               ce_i;
  logic               rx_i;
  logic               tx_o;
  logic               cts_n_i;
  logic               rts_n_o;
  logic [7:0]         tx_data_i;
  logic               tx_valid_i;
  logic               tx_ready_o;
  logic [7:0]         rx_data_o;
  logic               rx_valid_o;
  logic               rx_ready_i;
  logic [`BAUD_W-1:0] baud_rate_i;
  logic               baud_load_i;
  logic [`BAUD_W-1:0] baud_rate_o;
  logic               wake_enable_i;
  logic               device_wake_request_i;
  logic               radio_idle_i;
  logic               host_wake_o;
  logic               sleep_allowed_o;
  logic               frame_error_o;
  logic               overrun_o;
  logic [7:0]         devq[$];
  int                 bad_count = 0;
  int                 check_count = 0;
  int                 ovr_n = 0;
  int                 fe_n = 0;
  int                 cycles = 0;

  // ****************************************************************
  // design and partner
  // ****************************************************************
  hci_uart #(.FIFO_DEPTH(DEPTH)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .rx_i(rx_i), .tx_o(tx_o),
    .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .baud_rate_i(baud_rate_i),
    .baud_load_i(baud_load_i), .baud_rate_o(baud_rate_o),
    .wake_enable_i(wake_enable_i), .device_wake_request_i(device_wake_request_i),
    .radio_idle_i(radio_idle_i), .host_wake_o(host_wake_o),
    .sleep_allowed_o(sleep_allowed_o), .frame_error_o(frame_error_o),
    .overrun_o(overrun_o)
  );

  host_uart_model i_host (
    .clk_i(clk_i), .rx_line_i(tx_o), .tx_line_o(rx_i), .cts_n_o(cts_n_i),
    .rts_n_i(rts_n_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) devq.push_back(rx_data_o);
    if (overrun_o === 1'b1) ovr_n++;
    if (frame_error_o === 1'b1) fe_n++;
    if (cycles == 90000) begin
      bad_count++;
      $display("wrong value at %0t ns: run did not finish", $time);
      stop_test();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic push(input logic [7:0] b);
    int k;
    @(negedge clk_i);
    k = 0;
    while (tx_ready_o !== 1'b1 && k < 5000) begin
      @(negedge clk_i);
      k++;
    end
    tx_data_i = b;
    tx_valid_i = 1'b1;
    @(negedge clk_i);
    tx_valid_i = 1'b0;
  endtask

  task automatic wait_q(input int n, input bit host);
    int k;
    k = 0;
    while ((host ? i_host.rxq.size() : devq.size()) < n && k < 40000) begin
      @(negedge clk_i);
      k++;
    end
    cmp(host ? i_host.rxq.size() : devq.size(), n, "byte count");
  endtask

  task automatic xfer(input logic [7:0] h, input logic [7:0] d);
    devq.delete();
    i_host.rxq.delete();
    fork
      i_host.send_byte(h);
      push(d);
    join
    wait_q(1, 1'b1);
    wait_q(1, 1'b0);
    cmp(i_host.rxq[0], d, "host got");
    cmp(devq[0], h, "device got");
  endtask

  task automatic set_rate(input logic [20:0] req, input logic [20:0] exp);
    @(negedge clk_i);
    baud_rate_i = req;
    baud_load_i = 1'b1;
    @(negedge clk_i);
    baud_load_i = 1'b0;
    tick(3);
    cmp(baud_rate_o, exp, "rate in use");
    i_host.baud = exp;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    cmp(tx_o, 1, "tx idle");
    cmp(rts_n_o, 0, "rts after reset");
    cmp(tx_ready_o, 1, "tx ready");
    cmp(rx_valid_o, 0, "rx valid");
    cmp(baud_rate_o, `BAUD_DEFAULT, "default rate");
    cmp(host_wake_o, 0, "host wake off");
    cmp(sleep_allowed_o, 0, "sleep off");
    xfer(8'h01, 8'h04);
    $display("test reset_default ended");
  endtask

  task automatic t_rates;
    logic [20:0] r[3];
    int          i;
    r = '{21'h0e1000, 21'h07a120, 21'h16e360};
    set_rate(21'h1e8480, `BAUD_MAX);
    set_rate(21'h00c350, `BAUD_MIN);
    for (i = 0; i < 3; i++) begin
      set_rate(r[i], r[i]);
      xfer(8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
    end
    $display("test rates ended");
  endtask

  task automatic t_tolerance;
    set_rate(21'h0e1000, 21'h0e1000);
    i_host.err = 0.03;
    xfer(8'h96, 8'h69);
    i_host.err = -0.03;
    xfer(8'hf0, 8'h0f);
    i_host.err = 0.0;
    set_rate(`BAUD_MAX, `BAUD_MAX);
    $display("test tolerance ended");
  endtask

  task automatic t_cts;
    int k;
    i_host.rxq.delete();
    push(8'h11);
    push(8'h22);
    k = 0;
    while (tx_o !== 1'b0 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    i_host.cts_n_o = 1'b1;
    tick(1200);
    cmp(i_host.rxq.size(), 1, "only current char");
    cmp(tx_o, 1, "line idle while held");
    i_host.cts_n_o = 1'b0;
    wait_q(2, 1'b1);
    cmp(i_host.rxq[1], 8'h22, "held char");
    $display("test cts ended");
  endtask

  task automatic t_fill_wake;
    int n;
    int idle;
    i_host.rxq.delete();
    i_host.cts_n_o = 1'b1;
    n = 0;
    idle = 0;
    while (idle < 4) begin
      @(negedge clk_i);
      if (tx_ready_o === 1'b1) begin
        tx_data_i = n[7:0];
        tx_valid_i = 1'b1;
        n++;
        idle = 0;
      end else begin
        tx_valid_i = 1'b0;
        idle++;
      end
    end
    cmp(n, DEPTH + 1, "bytes accepted");
    cmp(host_wake_o, 0, "wake while disabled");
    wake_enable_i = 1'b1;
    device_wake_request_i = 1'b0;
    radio_idle_i = 1'b1;
    tick(3);
    cmp(host_wake_o, 1, "wake host");
    cmp(sleep_allowed_o, 0, "no sleep with traffic");
    i_host.cts_n_o = 1'b0;
    wait_q(DEPTH + 1, 1'b1);
    for (n = 0; n <= DEPTH; n++) cmp(i_host.rxq[n], n, "drain order");
    tick(40);
    cmp(host_wake_o, 0, "host may sleep");
    cmp(sleep_allowed_o, 1, "sleep allowed");
    device_wake_request_i = 1'b1;
    tick(3);
    cmp(sleep_allowed_o, 0, "kept awake by host");
    device_wake_request_i = 1'b0;
    radio_idle_i = 1'b0;
    tick(3);
    cmp(sleep_allowed_o, 0, "kept awake by radio");
    radio_idle_i = 1'b1;
    wake_enable_i = 1'b0;
    tick(3);
    cmp(sleep_allowed_o, 0, "sideband disabled");
    $display("test fill_wake ended");
  endtask

  task automatic t_rx_fill;
    int i;
    devq.delete();
    tick(1);
    rx_ready_i = 1'b0;
    // host ignores rts here on purpose to reach the overrun case
    i_host.honor_rts = 1'b0;
    for (i = 0; i < DEPTH + 3; i++) begin
      i_host.send_byte(8'h40 + i[7:0]);
      tick(4);
      if (i == 14) cmp(rts_n_o, 0, "rts below margin");
      if (i == 15) cmp(rts_n_o, 1, "rts at margin");
    end
    cmp(ovr_n, 2, "overrun count");
    rx_ready_i = 1'b1;
    i_host.honor_rts = 1'b1;
    wait_q(DEPTH + 1, 1'b0);
    for (i = 0; i <= DEPTH; i++) cmp(devq[i], 8'h40 + i, "rx order");
    tick(4);
    cmp(rts_n_o, 0, "rts after drain");
    $display("test rx_fill ended");
  endtask

  task automatic t_frame;
    int f0;
    devq.delete();
    f0 = fe_n;
    i_host.bad_stop = 1'b1;
    i_host.send_byte(8'h55);
    i_host.bad_stop = 1'b0;
    tick(4);
    cmp(fe_n, f0 + 1, "frame error pulse");
    cmp(devq.size(), 0, "bad byte dropped");
    // a frozen block must ignore the load strobe and keep its rate
    ce_i = 1'b0;
    set_rate(`BAUD_MIN, `BAUD_MAX);
    ce_i = 1'b1;
    xfer(8'h5a, 8'ha5);
    $display("test frame ended");
  endtask

  initial begin
    ce_i = 1'b1;
    tx_data_i = 8'h00;
    tx_valid_i = 1'b0;
    rx_ready_i = 1'b1;
    baud_rate_i = `BAUD_DEFAULT;
    baud_load_i = 1'b0;
    wake_enable_i = 1'b0;
    device_wake_request_i = 1'b1;
    radio_idle_i = 1'b0;
    rst_n_i = 1'b0;
    tick(5);
    rst_n_i = 1'b1;
    t_reset();
    t_rates();
    t_tolerance();
    t_cts();
    t_fill_wake();
    t_rx_fill();
    t_frame();
    stop_test();
  end
endmodule

//--- host_uart_model.sv
// host-side serial partner for the uart bench
`timescale 1ns/1ns

// ****************************************************************
// host uart model
// ****************************************************************
module host_uart_model (
  input  wire logic clk_i,
  input  wire logic rx_line_i,
  output logic      tx_line_o,
  output logic      cts_n_o,
  input  wire logic rts_n_i
);
  real        baud = 115200.0;
  real        err = 0.0;
  bit         honor_rts = 1'b1;
  bit         bad_stop = 1'b0;
  logic [7:0] rxq[$];

  initial begin
    tx_line_o = 1'h1;
    cts_n_o   = 1'h0;
  end

  task automatic wait_to(input real t);
    while ($realtime < t) @(negedge clk_i);
  endtask

  // edges snap to the falling clock edge: under one clock of jitter, no drift
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    real        t0;
    real        bn;
    int         k;
    fr = {~bad_stop, b, 1'b0};
    k = 0;
    while (honor_rts && rts_n_i === 1'b1 && k < 100000) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
    t0 = $realtime;
    bn = 1.0e9 / (baud * (1.0 + err));
    for (k = 0; k < 10; k++) begin
      tx_line_o = fr[k];
      wait_to(t0 + (k + 1) * bn);
    end
    tx_line_o = 1'h1;
    wait_to(t0 + 11.0 * bn);
  endtask

  initial begin : receiver
    logic [7:0] b;
    real        t0;
    real        bn;
    int         k;
    forever begin
      @(negedge rx_line_i);
      t0 = $realtime;
      bn = 1.0e9 / (baud * (1.0 + err));
      for (k = 0; k < 8; k++) begin
        wait_to(t0 + (k + 1.5) * bn);
        b[k] = rx_line_i;
      end
      wait_to(t0 + 9.5 * bn);
      // a low stop bit loses the byte, so the bench sees it as missing
      if (rx_line_i === 1'b1) rxq.push_back(b);
    end
  end
endmodule

//--- sync_fifo.sv
// synchronous fifo with registered output stage and registered ready
`timescale 1ns/1ns
`include "uart_defs.svh"

module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic   clk_i,
  input wire logic   rst_n_i,
  input wire logic   ce_i,
  byte_fifo_if.store f
);
  localparam int          AW      = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH-1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             ready_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             push;
  logic             load;

  // depth need not be a power of two, so pointers wrap explicitly
  assign push  = f.wr_valid & ready_q;
  assign load  = (cnt_q != '0) & (~out_valid_q | f.rd_ready);
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);

  assign f.wr_ready = ready_q;
  assign f.rd_valid = out_valid_q;
  assign f.rd_data  = out_data_q;
  assign f.level    = `LEVEL_W'(cnt_q) + `LEVEL_W'(out_valid_q);

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr_q] <= f.wr_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ready_q  <= 1'b1;
    end else if (ce_i) begin
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != DEPTH_C);
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (ce_i) begin
      if (load) begin
        out_valid_q <= 1'b1;
        out_data_q  <= mem[rd_ptr_q];
      end else if (f.rd_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= DEPTH_C) else $error("fifo count above depth");

  fifo_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_q == DEPTH_C) |-> !f.wr_ready) else $error("fifo full but ready");
endmodule

//--- uart_defs.svh
// constants of the host-interface uart: rates, sampling points, fifo sizes
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// ****************************************************************
// clock and baud range
// ****************************************************************
`define CLK_HZ          27'h2faf080
`define BAUD_W          21
`define BAUD_MIN        21'h01c200
`define BAUD_MAX        21'h16e360
`define BAUD_DEFAULT    21'h01c200

// ****************************************************************
// 16x oversampling points
// ****************************************************************
`define OVS_LAST        4'hf
`define START_CHECK     4'h7
`define VOTE_FIRST      4'h6
`define VOTE_LAST       4'h8
`define STOP_DONE       4'h9
`define LAST_BIT        3'h7

// ****************************************************************
// fifo sizes and flow control
// ****************************************************************
`define HCI_FIFO_DEPTH    1040
`define PERIPH_FIFO_DEPTH 256
`define LEVEL_W           16
`define RTS_MARGIN        16'h0010

`endif

//--- uart_pkg.sv
// types shared by the uart modules
`include "uart_defs.svh"

package uart_pkg;

  typedef logic [`BAUD_W-1:0] baud_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

endpackage
